// >>> posr_host.sv
`timescale 1ns/100ps
module posr_host (
  output logic link_clk_o, // Serial clock, idles high
  output logic link_cs_n_o, // Frame select, active low
  output logic link_mosi_o, // Serial data to device
  input wire logic link_miso_i // Serial data from device
);
  logic [7:0] rd [0:7];
  initial begin
    link_clk_o = 1'b1;
    link_cs_n_o = 1'b1;
    link_mosi_o = 1'b0;
  end
  // Slot 0 is the command byte, read data lands in slot i
  task automatic frame(input logic rw, input logic [6:0] a, input int n, input logic [7:0] wd);
    logic [7:0] b;
    link_cs_n_o = 1'b0;
    #23;
    for (int i = 0; i <= n; i++) begin
      b = (i == 0) ? {rw, a} : wd;
      for (int k = 7; k >= 0; k--) begin
        link_clk_o = 1'b0;
        link_mosi_o = b[k];
        #16;
        link_clk_o = 1'b1;
        rd[i][k] = link_miso_i;
        #16;
      end
      // Long high phase gives the device time to fetch read data
      #400;
    end
    link_cs_n_o = 1'b1;
    // Released line shows the inverse, never a stale bit
    link_mosi_o = ~link_mosi_o;
    #50;
  endtask
endmodule

// >>> posr_pkg.sv
package posr_pkg;
  // Register map, byte offsets on the serial register port
  localparam logic [6:0] ADDR_INT_CFG = 7'h0b;
  localparam logic [6:0] ADDR_THS_L = 7'h0c;
  localparam logic [6:0] ADDR_THS_H = 7'h0d;
  localparam logic [6:0] ADDR_IF_CTRL = 7'h0e;
  localparam logic [6:0] ADDR_CTRL1 = 7'h10;
  localparam logic [6:0] ADDR_CTRL2 = 7'h11;
  localparam logic [6:0] ADDR_CTRL3 = 7'h12;
  localparam logic [6:0] ADDR_QCTRL = 7'h13;
  localparam logic [6:0] ADDR_QWTM = 7'h14;
  localparam logic [6:0] ADDR_OFS_L = 7'h18;
  localparam logic [6:0] ADDR_OFS_H = 7'h19;
  localparam logic [6:0] ADDR_INT_SRC = 7'h24;
  localparam logic [6:0] ADDR_QSTAT1 = 7'h25;
  localparam logic [6:0] ADDR_QSTAT2 = 7'h26;
  localparam logic [6:0] ADDR_STATUS = 7'h27;
  localparam logic [6:0] ADDR_P_LOW = 7'h28;
  localparam logic [6:0] ADDR_P_MID = 7'h29;
  localparam logic [6:0] ADDR_P_HIGH = 7'h2a;
  localparam logic [6:0] ADDR_T_LOW = 7'h2b;
  localparam logic [6:0] ADDR_T_HIGH = 7'h2c;

  // Writable bits per register; fixed-zero bits are masked off
  localparam logic [7:0] MASK_THS_H = 8'h7f;
  localparam logic [7:0] MASK_IF_CTRL = 8'h9f;
  localparam logic [7:0] MASK_CTRL1 = 8'h7f;
  localparam logic [7:0] MASK_CTRL2 = 8'hf7;
  localparam logic [7:0] MASK_CTRL3 = 8'h3f;
  localparam logic [7:0] MASK_QCTRL = 8'h0f;
  localparam logic [7:0] MASK_QWTM = 8'h7f;

  // Values after reset
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h10;

  // Field positions
  localparam int C1_BDU = 1;
  localparam int C1_ODR_LSB = 4;
  localparam int C2_BOOT = 7;
  localparam int C2_ACT_LOW = 6;
  localparam int C2_OPEN_DRAIN = 5;
  localparam int C2_ADDR_INC = 4;
  localparam int C2_SOFT_RST = 2;
  localparam int C2_ONE_SHOT = 0;
  localparam int C3_READY_ROUTE_ENABLE = 2;
  localparam int C3_QIRQ_LSB = 3;
  localparam int SRC_BOOT_ON = 7;
  localparam int ST_P_DA = 0;
  localparam int ST_T_DA = 1;
  localparam int ST_P_OR = 4;
  localparam int ST_T_OR = 5;

  // Timing
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int BOOT_TIME_NS = 4500000;
  localparam int BOOT_CYCLES = BOOT_TIME_NS / SYS_CLK_PERIOD_NS;
  localparam int SOFT_RST_TIME_NS = 20000;
  localparam int SOFT_RST_CYCLES = SOFT_RST_TIME_NS / SYS_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_BOOT,
    MODE_RUN,
    MODE_REBOOT,
    MODE_SOFT_RST
  } posr_mode_t;

  typedef struct packed {
    logic [23:0] pressure;
    logic [15:0] temperature;
  } posr_sample_t;

  typedef struct packed {
    logic cmd;
    logic [7:0] data;
  } posr_link_byte_t;

  typedef struct packed {
    logic [7:0] interrupt_config;
    logic [7:0] threshold_low;
    logic [7:0] threshold_high;
    logic [7:0] interface_control;
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] control_three;
    logic [7:0] queue_control;
    logic [7:0] queue_watermark;
    logic [7:0] offset_comp_low;
    logic [7:0] offset_comp_high;
  } posr_cfg_t;
endpackage

// >>> posr_top.sv
`timescale 1ns/100ps
module posr_top #(
  parameter int BOOT_LEN = posr_pkg::BOOT_CYCLES
) (
  input wire logic sys_clk_i, // System clock, 25 MHz
  input wire logic arst_n_i, // Async reset, active low
  input wire logic link_clk_i, // Serial port clock, idles high
  input wire logic link_cs_n_i, // Serial port select, active low
  input wire logic link_mosi_i, // Serial data in
  output logic link_miso_o, // Serial data out
  output logic link_miso_oe_o, // Serial data out enable
  input wire logic sample_valid_i, // New sample pair, one-cycle pulse
  input wire posr_pkg::posr_sample_t sample_i, // Pressure and temperature
  input wire logic [2:0] queue_irq_i, // Queue full, watermark, overrun
  input wire logic [7:0] queue_status1_i, // Queue status byte one
  input wire logic [7:0] queue_status2_i, // Queue status byte two
  output posr_pkg::posr_cfg_t cfg_o, // Configuration registers
  output logic measure_trigger_o, // One-shot start pulse
  output logic trim_load_o, // Trim reload running
  output logic irq_output_pin_o, // Interrupt pin level
  output logic irq_output_pin_oe_o // Interrupt pin enable
);
  import posr_pkg::*;

  logic rst_q1;
  logic rst_n;

  // Link domain
  logic [2:0] bit_cnt, next_bit_cnt;
  logic first, next_first;
  logic rd, next_rd;
  logic [6:0] sh, next_sh;
  posr_link_byte_t rx, next_rx;
  logic rx_tog, next_rx_tog;
  logic [6:0] tx_sh, next_tx_sh;
  logic next_miso, next_miso_oe;

  // System domain
  logic tog_s1, tog_s2, tog_s3;
  logic ev;
  posr_mode_t mode, next_mode;
  logic [16:0] cnt, next_cnt;
  posr_cfg_t cfg, next_cfg;
  logic [6:0] cur_addr, next_cur_addr, fetch_addr, addr_inc;
  logic rd_mode, next_rd_mode;
  logic [7:0] hold, next_hold, rd_data, status_byte;
  logic [23:0] p_out, next_p_out, p_pend, next_p_pend;
  logic [15:0] t_out, next_t_out, t_pend, next_t_pend;
  logic p_pend_v, next_p_pend_v, t_pend_v, next_t_pend_v;
  logic p_lock, next_p_lock, t_lock, next_t_lock;
  logic p_rdy, next_p_rdy, t_rdy, next_t_rdy;
  logic p_or, next_p_or, t_or, next_t_or;
  logic q2_lock, next_q2_lock;
  logic [7:0] q2_snap, next_q2_snap;
  logic os_busy, next_os_busy;
  logic next_trig, boot_on, next_boot_on;
  logic irq_act, irq_lvl, next_irq_pin, next_irq_oe;
  logic block_update_enable, consume, wr_byte;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Mode 3 shifter: sample on rising edge, msb first
  always_comb begin
    next_bit_cnt = bit_cnt + 3'h1;
    next_sh = {sh[5:0], link_mosi_i};
    next_first = first;
    next_rd = rd;
    if (first && bit_cnt == 3'h0) begin
      next_rd = link_mosi_i;
    end
    if (bit_cnt == 3'h7) begin
      next_first = 1'b0;
    end
  end

  // Frame state is cleared by the frame's own select, not by a clock edge
  always_ff @(posedge link_clk_i or posedge link_cs_n_i) begin
    if (link_cs_n_i) begin
      bit_cnt <= 3'h0;
      first <= 1'b1;
      rd <= 1'b0;
      sh <= 7'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      first <= next_first;
      rd <= next_rd;
      sh <= next_sh;
    end
  end

  // Completed byte held stable for the system side, flagged by a toggle
  always_comb begin
    next_rx = rx;
    next_rx_tog = rx_tog;
    if (bit_cnt == 3'h7) begin
      next_rx = '{cmd: first, data: {sh, link_mosi_i}};
      next_rx_tog = ~rx_tog;
    end
  end

  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx <= '0;
      rx_tog <= 1'b0;
    end else begin
      rx <= next_rx;
      rx_tog <= next_rx_tog;
    end
  end

  // Hold is stable here because the host pauses the clock between bytes
  always_comb begin
    next_miso_oe = rd && !first;
    if (bit_cnt == 3'h0) begin
      next_miso = hold[7];
      next_tx_sh = hold[6:0];
    end else begin
      next_miso = tx_sh[6];
      next_tx_sh = {tx_sh[5:0], 1'b0};
    end
  end

  always_ff @(negedge link_clk_i or posedge link_cs_n_i) begin
    if (link_cs_n_i) begin
      tx_sh <= 7'h00;
      link_miso_o <= 1'b0;
      link_miso_oe_o <= 1'b0;
    end else begin
      tx_sh <= next_tx_sh;
      link_miso_o <= next_miso;
      link_miso_oe_o <= next_miso_oe;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= rx_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  assign ev = tog_s2 ^ tog_s3;
  assign block_update_enable = cfg.control_one[C1_BDU];

  always_comb begin
    if (!cfg.control_two[C2_ADDR_INC]) begin
      addr_inc = cur_addr;
    end else if (cur_addr == ADDR_T_HIGH) begin
      addr_inc = ADDR_P_LOW;
    end else begin
      addr_inc = cur_addr + 7'h01;
    end
    fetch_addr = rx.cmd ? rx.data[6:0] : addr_inc;
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_P_DA] = p_rdy;
    status_byte[ST_T_DA] = t_rdy;
    status_byte[ST_P_OR] = p_or;
    status_byte[ST_T_OR] = t_or;
    case (fetch_addr)
      ADDR_INT_CFG: rd_data = cfg.interrupt_config;
      ADDR_THS_L: rd_data = cfg.threshold_low;
      ADDR_THS_H: rd_data = cfg.threshold_high;
      ADDR_IF_CTRL: rd_data = cfg.interface_control;
      ADDR_CTRL1: rd_data = cfg.control_one;
      ADDR_CTRL2: rd_data = cfg.control_two;
      ADDR_CTRL3: rd_data = cfg.control_three;
      ADDR_QCTRL: rd_data = cfg.queue_control;
      ADDR_QWTM: rd_data = cfg.queue_watermark;
      ADDR_OFS_L: rd_data = cfg.offset_comp_low;
      ADDR_OFS_H: rd_data = cfg.offset_comp_high;
      ADDR_INT_SRC: rd_data = {boot_on, 7'h00};
      ADDR_QSTAT1: rd_data = queue_status1_i;
      ADDR_QSTAT2: rd_data = q2_lock ? q2_snap : queue_status2_i;
      ADDR_STATUS: rd_data = status_byte;
      ADDR_P_LOW: rd_data = p_out[7:0];
      ADDR_P_MID: rd_data = p_out[15:8];
      ADDR_P_HIGH: rd_data = p_out[23:16];
      ADDR_T_LOW: rd_data = t_out[7:0];
      ADDR_T_HIGH: rd_data = t_out[15:8];
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    next_mode = mode;
    next_cnt = cnt;
    next_cfg = cfg;
    next_cur_addr = cur_addr;
    next_rd_mode = rd_mode;
    next_hold = hold;
    next_p_out = p_out;
    next_t_out = t_out;
    next_p_pend = p_pend;
    next_t_pend = t_pend;
    next_p_pend_v = p_pend_v;
    next_t_pend_v = t_pend_v;
    next_p_lock = p_lock;
    next_t_lock = t_lock;
    next_p_rdy = p_rdy;
    next_t_rdy = t_rdy;
    next_p_or = p_or;
    next_t_or = t_or;
    next_q2_lock = q2_lock;
    next_q2_snap = q2_snap;
    next_os_busy = os_busy;
    next_trig = 1'b0;
    next_boot_on = boot_on;
    consume = ev && !rx.cmd && rd_mode && mode != MODE_BOOT;
    wr_byte = ev && !rx.cmd && !rd_mode && mode != MODE_BOOT;

    if (ev && mode != MODE_BOOT) begin
      next_cur_addr = fetch_addr;
      if (rx.cmd) begin
        next_rd_mode = rx.data[7];
      end
      if (rx.cmd ? rx.data[7] : rd_mode) begin
        next_hold = rd_data;
      end
    end

    if (consume) begin
      case (cur_addr)
        ADDR_P_LOW, ADDR_P_MID: next_p_lock = block_update_enable;
        // pressure released by its high byte
        ADDR_P_HIGH: begin
          next_p_rdy = 1'b0;
          next_p_lock = 1'b0;
        end
        ADDR_T_LOW: next_t_lock = block_update_enable;
        ADDR_T_HIGH: begin
          next_t_rdy = 1'b0;
          next_t_lock = 1'b0;
        end
        ADDR_QSTAT1: begin
          next_q2_lock = block_update_enable;
          next_q2_snap = queue_status2_i;
        end
        ADDR_QSTAT2: next_q2_lock = 1'b0;
        default: next_p_lock = p_lock;
      endcase
    end

    if (wr_byte) begin
      case (cur_addr)
        ADDR_INT_CFG: next_cfg.interrupt_config = rx.data;
        ADDR_THS_L: next_cfg.threshold_low = rx.data;
        ADDR_THS_H: next_cfg.threshold_high = rx.data & MASK_THS_H;
        ADDR_IF_CTRL: next_cfg.interface_control = rx.data & MASK_IF_CTRL;
        ADDR_CTRL1: next_cfg.control_one = rx.data & MASK_CTRL1;
        ADDR_CTRL2: next_cfg.control_two = rx.data & MASK_CTRL2;
        ADDR_CTRL3: next_cfg.control_three = rx.data & MASK_CTRL3;
        ADDR_QCTRL: next_cfg.queue_control = rx.data & MASK_QCTRL;
        ADDR_QWTM: next_cfg.queue_watermark = rx.data & MASK_QWTM;
        ADDR_OFS_L: next_cfg.offset_comp_low = rx.data;
        ADDR_OFS_H: next_cfg.offset_comp_high = rx.data;
        default: next_cfg = next_cfg;
      endcase
    end

    // Held-back sample enters once its lock drops
    if (!next_p_lock && p_pend_v) begin
      next_p_out = p_pend;
      next_p_pend_v = 1'b0;
      next_p_or = next_p_or | next_p_rdy;
      next_p_rdy = 1'b1;
    end
    if (!next_t_lock && t_pend_v) begin
      next_t_out = t_pend;
      next_t_pend_v = 1'b0;
      next_t_or = next_t_or | next_t_rdy;
      next_t_rdy = 1'b1;
    end

    // pressure passed through at its native scale
    if (sample_valid_i) begin
      if (next_p_lock) begin
        next_p_pend = sample_i.pressure;
        next_p_or = next_p_or | p_pend_v;
        next_p_pend_v = 1'b1;
      end else begin
        next_p_out = sample_i.pressure;
        next_p_or = next_p_or | next_p_rdy;
        // set wins over the read clear
        next_p_rdy = 1'b1;
      end
      if (next_t_lock) begin
        next_t_pend = sample_i.temperature;
        next_t_or = next_t_or | t_pend_v;
        next_t_pend_v = 1'b1;
      end else begin
        next_t_out = sample_i.temperature;
        next_t_or = next_t_or | next_t_rdy;
        next_t_rdy = 1'b1;
      end
    end

    // overruns drop once all data read
    if (!next_p_rdy && !next_t_rdy && !next_p_pend_v && !next_t_pend_v) begin
      next_p_or = 1'b0;
      next_t_or = 1'b0;
    end

    if (next_cfg.control_two[C2_ONE_SHOT] && !os_busy && mode == MODE_RUN) begin
      next_trig = 1'b1;
      next_os_busy = 1'b1;
    end
    if (sample_valid_i && os_busy) begin
      next_cfg.control_two[C2_ONE_SHOT] = 1'b0;
      next_os_busy = 1'b0;
    end

    unique case (mode)
      MODE_BOOT: begin
        next_cnt = cnt + 17'h00001;
        if (cnt == 17'(BOOT_LEN - 1)) begin
          next_mode = MODE_RUN;
          next_cnt = 17'h00000;
          next_boot_on = 1'b0;
        end
      end
      MODE_RUN: begin
        // Reboot takes priority if both bits arrive together
        if (next_cfg.control_two[C2_BOOT]) begin
          next_mode = MODE_REBOOT;
          next_boot_on = 1'b1;
        end else if (next_cfg.control_two[C2_SOFT_RST]) begin
          next_mode = MODE_SOFT_RST;
        end
      end
      MODE_REBOOT: begin
        next_cnt = cnt + 17'h00001;
        if (cnt == 17'(BOOT_LEN - 1)) begin
          next_cfg.offset_comp_low = RST_REG;
          next_cfg.offset_comp_high = RST_REG;
          next_cfg.control_one[C1_ODR_LSB +: 3] = 3'h0;
          next_cfg.control_two[C2_ONE_SHOT] = 1'b0;
          next_cfg.control_two[C2_BOOT] = 1'b0;
          next_os_busy = 1'b0;
          next_boot_on = 1'b0;
          next_cnt = 17'h00000;
          next_mode = MODE_RUN;
        end
      end
      MODE_SOFT_RST: begin
        next_cnt = cnt + 17'h00001;
        if (cnt == 17'(SOFT_RST_CYCLES - 1)) begin
          next_cfg.interrupt_config = RST_REG;
          next_cfg.threshold_low = RST_REG;
          next_cfg.threshold_high = RST_REG;
          next_cfg.interface_control = RST_REG;
          next_cfg.control_one = RST_REG;
          next_cfg.control_two = RST_CTRL2;
          next_cfg.control_three = RST_REG;
          next_cfg.queue_control = RST_REG;
          next_cfg.queue_watermark = RST_REG;
          next_p_rdy = 1'b0;
          next_t_rdy = 1'b0;
          next_p_or = 1'b0;
          next_t_or = 1'b0;
          next_p_lock = 1'b0;
          next_t_lock = 1'b0;
          next_p_pend_v = 1'b0;
          next_t_pend_v = 1'b0;
          next_q2_lock = 1'b0;
          next_os_busy = 1'b0;
          next_cnt = 17'h00000;
          next_mode = MODE_RUN;
        end
      end
    endcase
  end

  always_comb begin
    irq_act = (cfg.control_three[C3_READY_ROUTE_ENABLE] && cfg.control_three[1:0] == 2'b00 && p_rdy)
      || |(queue_irq_i & cfg.control_three[C3_QIRQ_LSB +: 3]);
    irq_lvl = irq_act ^ cfg.control_two[C2_ACT_LOW];
    if (cfg.control_two[C2_OPEN_DRAIN]) begin
      next_irq_pin = 1'b0;
      next_irq_oe = !irq_lvl;
    end else begin
      next_irq_pin = irq_lvl;
      next_irq_oe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_BOOT;
      cnt <= 17'h00000;
      cfg <= '{control_two: RST_CTRL2, default: RST_REG};
      cur_addr <= 7'h00;
      rd_mode <= 1'b0;
      hold <= 8'h00;
      p_out <= 24'h000000;
      t_out <= 16'h0000;
      p_pend <= 24'h000000;
      t_pend <= 16'h0000;
      p_pend_v <= 1'b0;
      t_pend_v <= 1'b0;
      p_lock <= 1'b0;
      t_lock <= 1'b0;
      p_rdy <= 1'b0;
      t_rdy <= 1'b0;
      p_or <= 1'b0;
      t_or <= 1'b0;
      q2_lock <= 1'b0;
      q2_snap <= 8'h00;
      os_busy <= 1'b0;
      measure_trigger_o <= 1'b0;
      boot_on <= 1'b1;
      irq_output_pin_o <= 1'b0;
      irq_output_pin_oe_o <= 1'b1;
    end else begin
      mode <= next_mode;
      cnt <= next_cnt;
      cfg <= next_cfg;
      cur_addr <= next_cur_addr;
      rd_mode <= next_rd_mode;
      hold <= next_hold;
      p_out <= next_p_out;
      t_out <= next_t_out;
      p_pend <= next_p_pend;
      t_pend <= next_t_pend;
      p_pend_v <= next_p_pend_v;
      t_pend_v <= next_t_pend_v;
      p_lock <= next_p_lock;
      t_lock <= next_t_lock;
      p_rdy <= next_p_rdy;
      t_rdy <= next_t_rdy;
      p_or <= next_p_or;
      t_or <= next_t_or;
      q2_lock <= next_q2_lock;
      q2_snap <= next_q2_snap;
      os_busy <= next_os_busy;
      measure_trigger_o <= next_trig;
      boot_on <= next_boot_on;
      irq_output_pin_o <= next_irq_pin;
      irq_output_pin_oe_o <= next_irq_oe;
    end
  end

  assign cfg_o = cfg;
  assign trim_load_o = boot_on;
endmodule

// >>> posr_top_monitor.sv
`timescale 1ns/100ps
module posr_top_monitor #(
  parameter int BOOT_LEN = 20
) (
  input wire logic sys_clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic sample_valid_i, // New sample pulse
  input wire logic [2:0] queue_irq_i, // Queue interrupt levels
  input wire posr_pkg::posr_cfg_t cfg_o, // Configuration registers
  input wire logic measure_trigger_o, // One-shot start
  input wire logic trim_load_o, // Boot running
  input wire logic irq_output_pin_o // Interrupt pin
);
  import posr_pkg::*;
  int boot_cnt;
  int next_boot_cnt;
  logic plain;
  assign plain = cfg_o.control_two[6:5] == 2'b00;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  always_comb begin
    next_boot_cnt = trim_load_o ? boot_cnt + 1 : 0;
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_cnt <= 0;
    end else begin
      boot_cnt <= next_boot_cnt;
    end
  end
  a_boot_len: assert property (boot_cnt <= BOOT_LEN + 4)
    else $error("boot runs too long");
  a_route_ready: assert property ((sample_valid_i && cfg_o.control_three[2:0] == 3'b100
    && plain && !cfg_o.control_one[1] && !trim_load_o) |-> ##[1:3] irq_output_pin_o)
    else $error("ready not routed to pin");
  a_queue_or: assert property (plain && |(queue_irq_i & cfg_o.control_three[5:3])
    |=> irq_output_pin_o)
    else $error("queue interrupt not on pin");
  a_pin_quiet: assert property (plain && !cfg_o.control_three[2]
    && !(|(queue_irq_i & cfg_o.control_three[5:3])) |=> !irq_output_pin_o)
    else $error("pin high without source");
  a_trig_pulse: assert property (measure_trigger_o |=> !measure_trigger_o)
    else $error("trigger longer than one cycle");
  a_shot_clear: assert property ((cfg_o.control_two[0] && sample_valid_i && !trim_load_o)
    |-> ##[1:3] !cfg_o.control_two[0])
    else $error("one-shot bit not cleared");
  a_reboot_zero: assert property ($fell(trim_load_o) |-> cfg_o.offset_comp_low == 8'h00
    && cfg_o.offset_comp_high == 8'h00 && !cfg_o.control_two[7])
    else $error("reboot left offsets or bit");
  a_swrst_end: assert property ($rose(cfg_o.control_two[2]) |-> ##[1:600] !cfg_o.control_two[2])
    else $error("soft reset never ends");
  a_swrst_dflt: assert property ($fell(cfg_o.control_two[2]) |-> cfg_o.control_one == 8'h00
    && cfg_o.control_three == 8'h00 && cfg_o.interrupt_config == 8'h00)
    else $error("soft reset left config");
endmodule
bind posr_top posr_top_monitor #(.BOOT_LEN(BOOT_LEN)) u_posr_top_monitor (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .sample_valid_i(sample_valid_i),
  .queue_irq_i(queue_irq_i), .cfg_o(cfg_o), .measure_trigger_o(measure_trigger_o),
  .trim_load_o(trim_load_o), .irq_output_pin_o(irq_output_pin_o));

// >>> posr_top_tb.sv
`timescale 1ns/100ps
module posr_top_tb;
  import posr_pkg::*;
  logic sys_clk, arst_n, sv, trig, trim, irq, irq_oe, sclk, cs_n, mosi, miso, miso_oe;
  wire miso_w = miso_oe ? miso : 1'bz;
  posr_sample_t smp;
  logic [2:0] qirq;
  posr_cfg_t cfg;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int shots = 0;
  posr_top #(.BOOT_LEN(20)) u_posr_top (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
    .link_clk_i(sclk), .link_cs_n_i(cs_n), .link_mosi_i(mosi), .link_miso_o(miso),
    .link_miso_oe_o(miso_oe), .sample_valid_i(sv), .sample_i(smp), .queue_irq_i(qirq),
    .queue_status1_i(8'h81), .queue_status2_i(8'h42), .cfg_o(cfg), .measure_trigger_o(trig),
    .trim_load_o(trim), .irq_output_pin_o(irq), .irq_output_pin_oe_o(irq_oe));
  posr_host u_posr_host (.link_clk_o(sclk), .link_cs_n_o(cs_n), .link_mosi_o(mosi),
    .link_miso_i(miso_w));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Sampled off the launching edge so a one-cycle trigger is seen settled
  always @(negedge sys_clk) begin
    cyc++;
    if (trig === 1'b1) begin
      shots++;
    end
    if (cyc == 8000) begin
      errors++;
      results();
    end
  end
  task automatic results;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_posr_host.frame(1'b0, a, 1, d);
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    u_posr_host.frame(1'b1, a, n, 8'h00);
  endtask
  task automatic put(input posr_sample_t s);
    @(negedge sys_clk);
    smp = s;
    sv = 1'b1;
    @(negedge sys_clk);
    sv = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic t_reset;
    rd(ADDR_CTRL2, 1);
    chk(u_posr_host.rd[1], RST_CTRL2);
    rd(7'h7f, 1);
    chk(u_posr_host.rd[1], 8'h00);
    rd(ADDR_QSTAT1, 2);
    chk(u_posr_host.rd[1], 8'h81);
    chk(u_posr_host.rd[2], 8'h42);
    rd(ADDR_INT_SRC, 1);
    chk(u_posr_host.rd[1] & 8'h80, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_flags;
    put({24'h123456, 16'h0789});
    put({24'h3e841a, 16'hfe7b});
    rd(ADDR_STATUS, 2);
    chk(u_posr_host.rd[1], 8'h33);
    rd(ADDR_STATUS, 1);
    chk(u_posr_host.rd[1], 8'h33);
    rd(ADDR_P_LOW, 6);
    chk(u_posr_host.rd[1], 8'h1a);
    chk(u_posr_host.rd[2], 8'h84);
    chk(u_posr_host.rd[3], 8'h3e);
    chk(u_posr_host.rd[4], 8'h7b);
    chk(u_posr_host.rd[5], 8'hfe);
    chk(u_posr_host.rd[6], 8'h1a);
    rd(ADDR_STATUS, 1);
    chk(u_posr_host.rd[1], 8'h00);
    $display("flags test done");
  endtask
  task automatic t_irq;
    wr(ADDR_CTRL3, 8'h04);
    put({24'h000000, 16'h0000});
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, irq_oe}, 8'h01);
    rd(ADDR_P_HIGH, 2);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_CTRL3, 8'h08);
    @(negedge sys_clk);
    qirq = 3'b110;
    repeat (3) @(negedge sys_clk);
    chk({7'h0, irq}, 8'h00);
    qirq = 3'b001;
    repeat (3) @(negedge sys_clk);
    chk({7'h0, irq}, 8'h01);
    qirq = 3'b000;
    wr(ADDR_CTRL3, 8'h00);
    $display("irq test done");
  endtask
  task automatic t_bdu;
    wr(ADDR_CTRL1, 8'h02);
    put({24'h000111, 16'h0a0b});
    rd(ADDR_T_LOW, 1);
    put({24'h222333, 16'hc0d0});
    rd(ADDR_T_HIGH, 2);
    chk(u_posr_host.rd[1], 8'h0a);
    rd(ADDR_P_HIGH, 1);
    chk(u_posr_host.rd[1], 8'h22);
    rd(ADDR_T_LOW, 1);
    chk(u_posr_host.rd[1], 8'hd0);
    $display("bdu test done");
  endtask
  task automatic t_boot;
    wr(ADDR_OFS_L, 8'h5a);
    chk(cfg.offset_comp_low, 8'h5a);
    wr(ADDR_CTRL2, 8'h90);
    for (int i = 0; i < 100 && trim !== 1'b0; i++) @(negedge sys_clk);
    rd(ADDR_INT_SRC, 1);
    chk(u_posr_host.rd[1] & 8'h80, 8'h00);
    chk(cfg.offset_comp_low, 8'h00);
    rd(ADDR_CTRL2, 1);
    chk(u_posr_host.rd[1], 8'h10);
    wr(ADDR_CTRL2, 8'h14);
    chk({7'h0, cfg.control_two[2]}, 8'h01);
    for (int i = 0; i < 600 && cfg.control_two[2] !== 1'b0; i++) @(negedge sys_clk);
    rd(ADDR_CTRL2, 1);
    chk(u_posr_host.rd[1], 8'h10);
    chk(cfg.control_one, 8'h00);
    $display("boot test done");
  endtask
  task automatic t_shot;
    wr(ADDR_CTRL2, 8'h11);
    chk(8'(shots), 8'h01);
    put({24'h000001, 16'h0001});
    rd(ADDR_CTRL2, 1);
    chk(u_posr_host.rd[1], 8'h10);
    wr(ADDR_CTRL2, 8'h11);
    chk(8'(shots), 8'h02);
    $display("shot test done");
  endtask
  initial begin
    arst_n = 1'b0;
    sv = 1'b0;
    smp = '0;
    qirq = 3'b000;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    t_reset();
    t_flags();
    t_irq();
    t_bdu();
    t_boot();
    t_shot();
    results();
  end
endmodule
